// ### core/tbec_top.sv
// Transmit bit formatting and data coder with register slave and FIFO
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "tbec_defs.svh"

module tbec_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              do_push = in_valid & in_ready;
  wire              do_pop  = out_valid & out_ready;

  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) wr_ptr <= wr_ptr + AW'(1);
      if (do_pop) rd_ptr <= rd_ptr + AW'(1);
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule : tbec_fifo

module tbec_top #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Avalon-MM slave
  input  wire logic [8:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Coded transmit stream
  output logic             tx_envelope,
  output logic             tx_subcarrier,
  output logic             tx_active
);
  // Quarter-bit length in clock cycles for a bit-rate code
  function automatic logic [10:0] quarter_len(input logic [2:0] sel);
    unique case (sel)
      `TBEC_RATE_53:  quarter_len = 11'(`TBEC_CLK_KHZ / (4 * `TBEC_RATE_53_KHZ));
      `TBEC_RATE_106: quarter_len = 11'(`TBEC_CLK_KHZ / (4 * `TBEC_RATE_106_KHZ));
      `TBEC_RATE_212: quarter_len = 11'(`TBEC_CLK_KHZ / (4 * `TBEC_RATE_212_KHZ));
      `TBEC_RATE_424: quarter_len = 11'(`TBEC_CLK_KHZ / (4 * `TBEC_RATE_424_KHZ));
      `TBEC_RATE_848: quarter_len = 11'(`TBEC_CLK_KHZ / (4 * `TBEC_RATE_848_KHZ));
      default:        quarter_len = 11'(`TBEC_CLK_KHZ / (4 * `TBEC_RATE_26_KHZ));
    endcase
  endfunction : quarter_len

  function automatic logic [7:0] bit_reverse(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      bit_reverse[i] = v[7-i];
    end
  endfunction : bit_reverse

  // Register file
  logic [7:0]  bit_format;
  logic [7:0]  data_coding;
  logic [7:0]  data_mod;
  logic        parity_en;
  logic        stop_en;
  logic        start_req;
  logic        read_ack;

  // Captured configuration
  logic [7:0]  cfg_bf;
  logic [7:0]  cfg_dc;
  logic [7:0]  cfg_dm;
  logic        cfg_par;
  logic        cfg_stop;

  // Sequencer
  tbec_pkg::tbec_state_type state;
  tbec_pkg::tbec_state_type next_state;
  logic [7:0]  tx_byte;
  logic [2:0]  bit_idx;
  logic [7:0]  slot;
  logic [1:0]  quarter;
  logic [10:0] tick;
  logic        prev_one;
  logic [5:0]  sc_cnt;
  logic        sc_phase;

  // FIFO link
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;

  wire         lane0    = avs_byteenable[0];
  wire         hit_bf   = avs_address == {`TBEC_IDX_BIT_FORMAT, 2'h0};
  wire         hit_dc   = avs_address == {`TBEC_IDX_DATA_CODING, 2'h0};
  wire         hit_dm   = avs_address == {`TBEC_IDX_DATA_MOD, 2'h0};
  wire         hit_ctrl = avs_address == {`TBEC_IDX_CTRL, 2'h0};
  wire         hit_stat = avs_address == {`TBEC_IDX_STATUS, 2'h0};
  wire         hit_data = avs_address == {`TBEC_IDX_TX_DATA, 2'h0};
  wire         wr_lane  = avs_write & lane0;
  wire         push_req = wr_lane & hit_data;
  wire         start_wr = wr_lane & hit_ctrl
                          & avs_writedata[`TBEC_CTRL_START];
  wire         busy     = state != tbec_pkg::TBEC_IDLE;

  // Full FIFO stalls the data write
  assign avs_waitrequest = (avs_read & ~read_ack)
                           | (push_req & ~fifo_in_ready);

  wire [7:0] ctrl_view = {5'h00, stop_en, parity_en, start_req};
  wire [7:0] stat_view = {5'h00, ~fifo_in_ready, ~fifo_out_valid, busy};
  wire [7:0] rd_mux = hit_bf   ? (bit_format & `TBEC_BIT_FORMAT_MASK) :
                      hit_dc   ? data_coding :
                      hit_dm   ? data_mod :
                      hit_ctrl ? ctrl_view :
                      hit_stat ? stat_view : `TBEC_REG_RESET;

  // Live and captured fields
  wire        launch    = (state == tbec_pkg::TBEC_IDLE) & start_req
                          & fifo_out_valid;
  wire [3:0]  code      = cfg_dc[`TBEC_DC_CODE_HI:`TBEC_DC_CODE_LO];
  wire [1:0]  pulse_sel = cfg_dm[`TBEC_DM_PULSE_HI:`TBEC_DM_PULSE_LO];
  wire        miller    = cfg_dm[`TBEC_DM_MILLER];
  wire [2:0]  env_kind  = cfg_dm[`TBEC_DM_ENV_HI:`TBEC_DM_ENV_LO];
  wire        framestep = cfg_dm[`TBEC_DM_FRAMESTEP];
  wire [10:0] qlen_live =
    quarter_len(data_coding[`TBEC_DC_RATE_HI:`TBEC_DC_RATE_LO]);
  wire [10:0] qlen      = launch ? qlen_live :
    quarter_len(cfg_dc[`TBEC_DC_RATE_HI:`TBEC_DC_RATE_LO]);
  wire        q_tick    = tick == 11'h000;
  wire        slot_end  = q_tick & (quarter == `TBEC_QUARTER_LAST);

  // Coding class decode
  wire is_chip = (code == `TBEC_CODE_NONE) | (code == `TBEC_CODE_COLLIDER);
  wire is_rz   = (code >= `TBEC_CODE_RZ_FIRST) & (code <= `TBEC_CODE_RZ_LAST);
  wire is_4    = code == `TBEC_CODE_ONE_OF_4;
  wire is_256  = (code >= `TBEC_CODE_256_FULL) & (code <= `TBEC_CODE_256_LAST);
  wire is_pie  = code == `TBEC_CODE_PIE;

  wire [7:0] ordered  = cfg_bf[`TBEC_BF_HIGH_FIRST] ? bit_reverse(tx_byte)
                                                    : tx_byte;
  wire       cur_bit  = ordered[bit_idx];
  wire       nxt_bit  = ordered[bit_idx + 3'h1];
  wire [1:0] pair     = cfg_bf[`TBEC_BF_HIGH_FIRST] ? {cur_bit, nxt_bit}
                                                    : {nxt_bit, cur_bit};
  wire       par_bit  = (^tx_byte) ^ cfg_bf[`TBEC_BF_PARITY_ODD];
  wire [7:0] pie_last = cur_bit ? `TBEC_PIE_ONE_LAST : `TBEC_PIE_ZERO_LAST;

  // Symbol and byte boundaries in the data phase
  wire sym_end   = is_4   ? slot == `TBEC_SLOT_LAST_4 :
                   is_256 ? slot == `TBEC_SLOT_LAST_256 :
                   is_pie ? slot == pie_last : 1'b1;
  wire [2:0] bit_step = is_4 ? 3'h2 : 3'h1;
  wire [2:0] bit_last = is_4 ? 3'h6 : 3'h7;
  wire data_last = sym_end & (is_256 | (bit_idx == bit_last));

  // One-of-256 slot match with zero variants
  wire zero_val  = tx_byte == 8'h00;
  wire hit_256   = (code == `TBEC_CODE_256_SILENT) & zero_val ? 1'b0 :
                   (code == `TBEC_CODE_256_LAST) & zero_val
                     ? slot == `TBEC_SLOT_LAST_256 : slot == tx_byte;

  wire chip_bit = state == tbec_pkg::TBEC_START
                    ? cfg_bf[`TBEC_BF_START_LEVEL] :
                  state == tbec_pkg::TBEC_PARITY ? par_bit :
                  state == tbec_pkg::TBEC_STOP
                    ? cfg_bf[`TBEC_BF_STOP_LEVEL] :
                  is_4   ? slot[1:0] == pair :
                  is_256 ? hit_256 : cur_bit;

  wire shaped = pulse_sel == `TBEC_PULSE_NONE  ? chip_bit :
                pulse_sel == `TBEC_PULSE_START
                  ? chip_bit & (quarter == `TBEC_QUARTER_FIRST) :
                pulse_sel == `TBEC_PULSE_HALF  ? chip_bit & quarter[1] :
                chip_bit & (quarter == `TBEC_QUARTER_MID);
  wire miller_env = chip_bit ? quarter == `TBEC_QUARTER_MID
                             : ~prev_one & (quarter == `TBEC_QUARTER_FIRST);
  wire chip_env   = miller ? miller_env : shaped;
  wire in_data    = state == tbec_pkg::TBEC_DATA;

  wire data_env = is_chip ? chip_env :
                  is_rz   ? cur_bit & (quarter == code[1:0]) :
                  (is_4 | is_256) ? chip_env :
                  is_pie  ? ~((slot == pie_last) & quarter[1]) : 1'b0;
  wire env_raw  = in_data ? data_env :
                  (state == tbec_pkg::TBEC_GAP) ? 1'b0 : chip_env;
  wire framing  = busy & (state != tbec_pkg::TBEC_GAP);
  wire env_out  = framing & (env_raw ^ cfg_dm[`TBEC_DM_INVERT]);

  wire [5:0] sc_half = cfg_dc[`TBEC_DC_SUBCARRIER]
                       ? 6'(`TBEC_CLK_KHZ / (2 * `TBEC_SC_848_KHZ))
                       : 6'(`TBEC_CLK_KHZ / (2 * `TBEC_SC_424_KHZ));

  // End of the last element of a byte
  wire byte_done = slot_end & (
    (state == tbec_pkg::TBEC_STOP) |
    (state == tbec_pkg::TBEC_PARITY & ~cfg_stop) |
    (in_data & data_last & ~cfg_par & ~cfg_stop));
  wire gap_done  = slot_end & (state == tbec_pkg::TBEC_GAP);
  wire chain     = (byte_done & ~framestep) | gap_done;
  wire fifo_pop  = launch | (chain & fifo_out_valid);
  wire load_byte = fifo_pop;
  wire start_en  = launch ? bit_format[`TBEC_BF_START_EN]
                          : cfg_bf[`TBEC_BF_START_EN];
  wire [2:0] first_state_sel = start_en ? 3'h1 : 3'h2;

  always_comb begin
    next_state = state;
    unique case (state)
      tbec_pkg::TBEC_IDLE: begin
        if (launch) next_state = start_en ? tbec_pkg::TBEC_START
                                          : tbec_pkg::TBEC_DATA;
      end
      tbec_pkg::TBEC_START: begin
        if (slot_end) next_state = tbec_pkg::TBEC_DATA;
      end
      tbec_pkg::TBEC_DATA: begin
        if (slot_end & data_last) begin
          next_state = cfg_par  ? tbec_pkg::TBEC_PARITY :
                       cfg_stop ? tbec_pkg::TBEC_STOP : tbec_pkg::TBEC_IDLE;
        end
      end
      tbec_pkg::TBEC_PARITY: begin
        if (slot_end) next_state = cfg_stop ? tbec_pkg::TBEC_STOP
                                            : tbec_pkg::TBEC_IDLE;
      end
      tbec_pkg::TBEC_STOP: begin
        if (slot_end) next_state = tbec_pkg::TBEC_IDLE;
      end
      tbec_pkg::TBEC_GAP: begin
        if (slot_end) next_state = tbec_pkg::TBEC_IDLE;
      end
    endcase
    if (byte_done & framestep) next_state = tbec_pkg::TBEC_GAP;
    if (chain) begin
      next_state = !fifo_out_valid ? tbec_pkg::TBEC_IDLE :
                   first_state_sel[0] ? tbec_pkg::TBEC_START
                                      : tbec_pkg::TBEC_DATA;
    end
  end

  // Register slave
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bit_format   <= `TBEC_REG_RESET;
      data_coding  <= `TBEC_REG_RESET;
      data_mod     <= `TBEC_REG_RESET;
      parity_en    <= 1'b0;
      stop_en      <= 1'b0;
      start_req    <= 1'b0;
      read_ack     <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      read_ack <= avs_read & ~read_ack;
      if (avs_read & ~read_ack) avs_readdata <= {24'h00_0000, rd_mux};
      if (wr_lane & hit_bf) begin
        bit_format <= avs_writedata[7:0] & `TBEC_BIT_FORMAT_MASK;
      end
      if (wr_lane & hit_dc) data_coding <= avs_writedata[7:0];
      if (wr_lane & hit_dm) data_mod <= avs_writedata[7:0];
      if (wr_lane & hit_ctrl) begin
        parity_en <= avs_writedata[`TBEC_CTRL_PARITY_EN];
        stop_en   <= avs_writedata[`TBEC_CTRL_STOP_EN];
      end
      start_req <= start_wr | (start_req & ~launch);
    end
  end

  // Sequencer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state    <= tbec_pkg::TBEC_IDLE;
      cfg_bf   <= `TBEC_REG_RESET;
      cfg_dc   <= `TBEC_REG_RESET;
      cfg_dm   <= `TBEC_REG_RESET;
      cfg_par  <= 1'b0;
      cfg_stop <= 1'b0;
      tx_byte  <= 8'h00;
      bit_idx  <= 3'h0;
      slot     <= 8'h00;
      quarter  <= 2'h0;
      tick     <= 11'h000;
      prev_one <= 1'b0;
    end else begin
      state <= next_state;
      if (launch) begin
        cfg_bf   <= bit_format;
        cfg_dc   <= data_coding;
        cfg_dm   <= data_mod;
        cfg_par  <= parity_en;
        cfg_stop <= stop_en;
      end
      if (load_byte) begin
        tx_byte <= fifo_out_data;
        bit_idx <= 3'h0;
        slot    <= 8'h00;
      end else if (slot_end & in_data) begin
        slot    <= sym_end ? 8'h00 : slot + 8'h01;
        bit_idx <= sym_end ? bit_idx + bit_step : bit_idx;
      end
      if (launch) begin
        tick    <= qlen - 11'h001;
        quarter <= 2'h0;
      end else if (busy) begin
        tick    <= q_tick ? qlen - 11'h001 : tick - 11'h001;
        quarter <= q_tick ? quarter + 2'h1 : quarter;
      end
      if (launch) prev_one <= 1'b0;
      else if (slot_end) prev_one <= chip_bit;
    end
  end

  // Output stage and subcarrier
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sc_cnt        <= 6'h00;
      sc_phase      <= 1'b0;
      tx_envelope   <= 1'b0;
      tx_subcarrier <= 1'b0;
      tx_active     <= 1'b0;
    end else begin
      sc_cnt   <= (sc_cnt == 6'h00) ? sc_half - 6'h01 : sc_cnt - 6'h01;
      sc_phase <= (sc_cnt == 6'h00) ? ~sc_phase : sc_phase;
      tx_envelope   <= env_out;
      tx_subcarrier <= env_out & sc_phase & (env_kind != 3'h0);
      tx_active     <= framing;
    end
  end

  tbec_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (push_req),
    .in_ready  (fifo_in_ready),
    .in_data   (avs_writedata[7:0]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );
endmodule : tbec_top

// ### core/tbec_defs.svh
// Offsets, field positions, codes and timing of the transmit bit coder
`ifndef TBEC_DEFS_SVH
`define TBEC_DEFS_SVH

// Register indices; byte address is four times the index
`define TBEC_IDX_BIT_FORMAT   7'h48
`define TBEC_IDX_DATA_CODING  7'h4a
`define TBEC_IDX_DATA_MOD     7'h4b
`define TBEC_IDX_CTRL         7'h50
`define TBEC_IDX_STATUS       7'h51
`define TBEC_IDX_TX_DATA      7'h52

`define TBEC_REG_RESET        8'h00
`define TBEC_BIT_FORMAT_MASK  8'hab

// Bit-format fields
`define TBEC_BF_HIGH_FIRST    7
`define TBEC_BF_PARITY_ODD    5
`define TBEC_BF_STOP_LEVEL    3
`define TBEC_BF_START_LEVEL   1
`define TBEC_BF_START_EN      0

// Data-coding fields
`define TBEC_DC_CODE_HI       7
`define TBEC_DC_CODE_LO       4
`define TBEC_DC_SUBCARRIER    3
`define TBEC_DC_RATE_HI       2
`define TBEC_DC_RATE_LO       0

// Data-modulation fields
`define TBEC_DM_FRAMESTEP     7
`define TBEC_DM_MILLER        6
`define TBEC_DM_PULSE_HI      5
`define TBEC_DM_PULSE_LO      4
`define TBEC_DM_INVERT        3
`define TBEC_DM_ENV_HI        2
`define TBEC_DM_ENV_LO        0

// Control and status fields
`define TBEC_CTRL_START       0
`define TBEC_CTRL_PARITY_EN   1
`define TBEC_CTRL_STOP_EN     2
`define TBEC_ST_BUSY          0
`define TBEC_ST_EMPTY         1
`define TBEC_ST_FULL          2

// Coding type codes
`define TBEC_CODE_NONE        4'h0
`define TBEC_CODE_COLLIDER    4'h1
`define TBEC_CODE_RZ_FIRST    4'h4
`define TBEC_CODE_RZ_LAST     4'h7
`define TBEC_CODE_ONE_OF_4    4'h8
`define TBEC_CODE_256_FULL    4'h9
`define TBEC_CODE_256_SILENT  4'ha
`define TBEC_CODE_256_LAST    4'hb
`define TBEC_CODE_PIE         4'hc

// Pulse position codes
`define TBEC_PULSE_NONE       2'h0
`define TBEC_PULSE_START      2'h1
`define TBEC_PULSE_HALF       2'h2
`define TBEC_PULSE_QUARTER3   2'h3

// Last slot and quarter indices inside one symbol
`define TBEC_SLOT_LAST_4      8'h03
`define TBEC_SLOT_LAST_256    8'hff
`define TBEC_PIE_ZERO_LAST    8'h01
`define TBEC_PIE_ONE_LAST     8'h03
`define TBEC_QUARTER_LAST     2'h3
`define TBEC_QUARTER_MID      2'h2
`define TBEC_QUARTER_FIRST    2'h0

// Frequencies and bit-rate select codes
`define TBEC_CLK_KHZ          50000
`define TBEC_RATE_26_KHZ      26
`define TBEC_RATE_53_KHZ      53
`define TBEC_RATE_106_KHZ     106
`define TBEC_RATE_212_KHZ     212
`define TBEC_RATE_424_KHZ     424
`define TBEC_RATE_848_KHZ     848
`define TBEC_SC_424_KHZ       424
`define TBEC_SC_848_KHZ       848
`define TBEC_RATE_53          3'h3
`define TBEC_RATE_106         3'h4
`define TBEC_RATE_212         3'h5
`define TBEC_RATE_424         3'h6
`define TBEC_RATE_848         3'h7

`endif

// ### core/tbec_pkg.sv
// Types shared by the transmit bit coder
package tbec_pkg;
  typedef enum logic [2:0] {
    TBEC_IDLE,
    TBEC_START,
    TBEC_DATA,
    TBEC_PARITY,
    TBEC_STOP,
    TBEC_GAP
  } tbec_state_type;
endpackage : tbec_pkg

// ### verif/tbec_properties.sv
// Port checks for the transmit bit coder
`timescale 1ns/1ps
`include "tbec_defs.svh"
module tbec_checker #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Register bus
  input wire logic [8:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Coded stream
  input wire logic        tx_envelope,
  input wire logic        tx_subcarrier,
  input wire logic        tx_active
);
  wire logic [6:0] idx     = avs_address[8:2];
  wire logic       rd_done = avs_read && !avs_waitrequest;
  wire logic       mapped  = idx inside {`TBEC_IDX_BIT_FORMAT,
    `TBEC_IDX_DATA_CODING, `TBEC_IDX_DATA_MOD, `TBEC_IDX_CTRL,
    `TBEC_IDX_STATUS, `TBEC_IDX_TX_DATA};

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_read_wait;
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read wait state wrong");
  property p_write_wait;
    avs_write && avs_waitrequest |-> idx == `TBEC_IDX_TX_DATA;
  endproperty
  a_write_wait: assert property (p_write_wait)
    else $error("config write stalled");
  property p_rd_hold;
    !(avs_read && avs_waitrequest) |=> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved");
  property p_bf_reserved;
    rd_done && idx == `TBEC_IDX_BIT_FORMAT
      |-> (avs_readdata & ~32'h000000ab) == 0;
  endproperty
  a_bf_reserved: assert property (p_bf_reserved)
    else $error("reserved format bits set");
  property p_upper_zero;
    rd_done |-> avs_readdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read lanes set");
  property p_unmapped;
    rd_done && !mapped |-> avs_readdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_idle_quiet;
    !tx_active |-> !tx_envelope;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("envelope outside frame");
  property p_sub_in_frame;
    tx_subcarrier |-> tx_active;
  endproperty
  a_sub_in_frame: assert property (p_sub_in_frame)
    else $error("subcarrier outside frame");
  property p_frame_min;
    $rose(tx_active) |-> tx_active [*8];
  endproperty
  a_frame_min: assert property (p_frame_min)
    else $error("frame too short");
endmodule : tbec_checker

bind tbec_top tbec_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .clk(clk), .rst_b(rst_b), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .tx_envelope(tx_envelope), .tx_subcarrier(tx_subcarrier),
  .tx_active(tx_active));

// ### verif/tbec_card_model.sv
// Card-side receiver that samples the envelope at mid-bit
`timescale 1ns/1ps
module tbec_card_model #(
  parameter int BIT_LEN = 56
) (
  // Clock and reset
  input wire logic    clk,
  input wire logic    rst_b,
  // Air side
  input wire logic    tx_envelope,
  input wire logic    tx_active,
  // Captured frame
  output logic [63:0] rx_bits,
  output logic [7:0]  rx_count,
  output logic [7:0]  rx_frames
);
  logic act_q;
  int   phase;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      act_q <= 1'b0;
      phase <= 0;
      rx_bits <= '0;
      rx_count <= '0;
      rx_frames <= '0;
    end else begin
      act_q <= tx_active;
      if (tx_active && !act_q) begin
        phase <= 1;
        rx_bits <= '0;
        rx_count <= '0;
        rx_frames <= rx_frames + 8'h01;
      end else if (tx_active) begin
        phase <= (phase == BIT_LEN - 1) ? 0 : phase + 1;
        if (phase == BIT_LEN / 2) begin
          rx_bits <= {rx_bits[62:0], tx_envelope};
          rx_count <= rx_count + 8'h01;
        end
      end
    end
  end
endmodule : tbec_card_model

// ### verif/tbec_top_tb.sv
// Self-checking bench for the transmit bit coder
`timescale 1ns/1ps
`include "tbec_defs.svh"
`define TBEC_CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp); \
    end \
  end
module tbec_top_tb;
  localparam int QUARTER = `TBEC_CLK_KHZ / (4 * `TBEC_RATE_848_KHZ);
  localparam logic [6:0] I_BF = `TBEC_IDX_BIT_FORMAT;
  localparam logic [6:0] I_DC = `TBEC_IDX_DATA_CODING;
  localparam logic [6:0] I_DM = `TBEC_IDX_DATA_MOD;
  localparam logic [6:0] I_CT = `TBEC_IDX_CTRL;
  localparam logic [6:0] I_ST = `TBEC_IDX_STATUS;
  localparam logic [6:0] I_TX = `TBEC_IDX_TX_DATA;
  logic        clk;
  logic        rst_b;
  logic [8:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        tx_envelope;
  logic        tx_subcarrier;
  logic        tx_active;
  logic [63:0] card_bits;
  logic [7:0]  card_count;
  logic [7:0]  card_frames;
  int          miscompares;
  int          comparisons;
  int          sc_hits;

  tbec_top #(.FIFO_DEPTH(16)) dut (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_envelope(tx_envelope),
    .tx_subcarrier(tx_subcarrier), .tx_active(tx_active));
  tbec_card_model #(.BIT_LEN(4 * QUARTER)) card (.clk(clk),
    .rst_b(rst_b), .tx_envelope(tx_envelope), .tx_active(tx_active),
    .rx_bits(card_bits), .rx_count(card_count),
    .rx_frames(card_frames));

  always_ff @(posedge clk) if (tx_subcarrier) sc_hits <= sc_hits + 1;

  task automatic conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [6:0] idx,
                     input logic [7:0] wd, input logic [3:0] be,
                     output logic [31:0] rd);
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, wd};
    avs_byteenable <= be;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    do @(posedge clk);
    while (avs_waitrequest);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wait_done;
    int   k;
    int   idle;
    logic seen;
    idle = 0;
    seen = 1'b0;
    for (k = 0; k < 20000 && idle < 200; k++) begin
      @(negedge clk);
      if (tx_active) seen = 1'b1;
      idle = (seen && !tx_active) ? idle + 1 : 0;
    end
    `TBEC_CHK(seen, 1'b1)
  endtask : wait_done

  task automatic run_frame(input logic [7:0] bf, input logic [2:0] ctl,
                           input logic [7:0] md, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, I_BF, bf, 4'h1, r);
    bus(1'b1, I_DC, 8'h07, 4'h1, r);
    bus(1'b1, I_DM, md, 4'h1, r);
    bus(1'b1, I_TX, d, 4'h1, r);
    bus(1'b1, I_CT, {5'h00, ctl}, 4'h1, r);
    wait_done();
  endtask : run_frame

  task automatic check_frame(input logic [7:0] bf, input logic [2:0] ctl,
                             input logic [7:0] d, input logic inv);
    logic [63:0] e;
    logic [7:0]  n;
    int          i;
    e = '0;
    n = 8'h00;
    if (bf[0]) {e, n} = {e[62:0], bf[1], n + 8'h01};
    for (i = 0; i < 8; i++) begin
      {e, n} = {e[62:0], bf[7] ? d[7-i] : d[i], n + 8'h01};
    end
    if (ctl[1]) {e, n} = {e[62:0], ^d ^ bf[5], n + 8'h01};
    if (ctl[2]) {e, n} = {e[62:0], bf[3], n + 8'h01};
    if (inv) e = ~e & ((64'h1 << n) - 64'h1);
    `TBEC_CHK(card_count, n)
    `TBEC_CHK(card_bits, e)
  endtask : check_frame

  task automatic t_regs;
    logic [31:0] r;
    logic [4:0]  c;
    bus(1'b1, I_BF, 8'hff, 4'h1, r);
    bus(1'b0, I_BF, 8'h00, 4'h1, r);
    `TBEC_CHK(r, 32'h000000ab)
    for (c = 5'h00; c < 5'h10; c++) begin
      bus(1'b1, I_DC, {c[3:0], c[3:0]}, 4'h1, r);
      bus(1'b0, I_DC, 8'h00, 4'h1, r);
      `TBEC_CHK(r, {24'h000000, c[3:0], c[3:0]})
    end
    bus(1'b1, I_DC, 8'h00, 4'h0, r);
    bus(1'b0, I_DC, 8'h00, 4'h1, r);
    `TBEC_CHK(r, 32'h000000ff)
    bus(1'b1, 7'h49, 8'hff, 4'h1, r);
    bus(1'b0, 7'h49, 8'h00, 4'h1, r);
    `TBEC_CHK(r, 32'h00000000)
  endtask : t_regs

  task automatic t_order;
    run_frame(8'h00, 3'h1, 8'h00, 8'hc5);
    check_frame(8'h00, 3'h1, 8'hc5, 1'b0);
    run_frame(8'h83, 3'h1, 8'h00, 8'hc5);
    check_frame(8'h83, 3'h1, 8'hc5, 1'b0);
    run_frame(8'h81, 3'h1, 8'h00, 8'h3a);
    check_frame(8'h81, 3'h1, 8'h3a, 1'b0);
  endtask : t_order

  task automatic t_parity_stop;
    run_frame(8'h28, 3'h7, 8'h00, 8'hc5);
    check_frame(8'h28, 3'h7, 8'hc5, 1'b0);
    run_frame(8'h00, 3'h7, 8'h00, 8'hc4);
    check_frame(8'h00, 3'h7, 8'hc4, 1'b0);
  endtask : t_parity_stop

  task automatic t_invert;
    run_frame(8'h01, 3'h5, 8'h08, 8'h3c);
    check_frame(8'h01, 3'h5, 8'h3c, 1'b1);
  endtask : t_invert

  task automatic t_framestep;
    logic [31:0] r;
    logic [7:0]  f;
    f = card_frames;
    bus(1'b1, I_TX, 8'h11, 4'h1, r);
    run_frame(8'h00, 3'h1, 8'h80, 8'h22);
    `TBEC_CHK(card_frames - f, 8'h02)
    check_frame(8'h00, 3'h1, 8'h22, 1'b0);
  endtask : t_framestep

  task automatic t_fifo;
    logic [31:0] r;
    logic [7:0]  f;
    int          i;
    bus(1'b1, I_DM, 8'h00, 4'h1, r);
    for (i = 0; i < 16; i++) bus(1'b1, I_TX, i[7:0], 4'h1, r);
    bus(1'b0, I_ST, 8'h00, 4'h1, r);
    `TBEC_CHK(r, 32'h00000004)
    f = card_frames;
    bus(1'b1, I_CT, 8'h01, 4'h1, r);
    bus(1'b1, I_TX, 8'haa, 4'h1, r);
    wait_done();
    `TBEC_CHK(card_frames - f, 8'h01)
    `TBEC_CHK(card_count, 8'd136)
    bus(1'b0, I_ST, 8'h00, 4'h1, r);
    `TBEC_CHK(r, 32'h00000002)
  endtask : t_fifo

  task automatic run_code(input logic [7:0] dc, input logic [7:0] d,
                          input logic [7:0] n, input logic [63:0] e);
    logic [31:0] r;
    bus(1'b1, I_BF, 8'h00, 4'h1, r);
    bus(1'b1, I_DC, dc, 4'h1, r);
    bus(1'b1, I_DM, 8'h00, 4'h1, r);
    bus(1'b1, I_TX, d, 4'h1, r);
    bus(1'b1, I_CT, 8'h01, 4'h1, r);
    wait_done();
    `TBEC_CHK(card_count, n)
    `TBEC_CHK(card_bits, e)
  endtask : run_code

  task automatic t_coding;
    run_code(8'h67, 8'h5a, 8'h08, 64'h5a);
    run_code(8'h47, 8'hff, 8'h08, 64'h0);
    run_code(8'h87, 8'h1b, 8'h10, 64'h1248);
    run_code(8'hc7, 8'h01, 8'h12, 64'h3aaaa);
    run_code(8'hb7, 8'h00, 8'h00, 64'h1);
    run_code(8'ha7, 8'h00, 8'h00, 64'h0);
  endtask : t_coding

  task automatic t_shape;
    `TBEC_CHK(sc_hits, 0)
    run_frame(8'h00, 3'h1, 8'h20, 8'h5a);
    check_frame(8'h00, 3'h1, 8'h5a, 1'b0);
    run_frame(8'h00, 3'h1, 8'h50, 8'h5a);
    check_frame(8'h00, 3'h1, 8'h5a, 1'b0);
    run_frame(8'h00, 3'h1, 8'h10, 8'hff);
    `TBEC_CHK(card_bits, 64'h0)
    run_frame(8'h00, 3'h1, 8'h01, 8'hff);
    `TBEC_CHK(sc_hits != 0, 1'b1)
  endtask : t_shape

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    conclude();
  end

  initial begin
    rst_b <= 1'b0;
    avs_address <= '0;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= '0;
    avs_byteenable <= 4'h1;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_order();
    t_parity_stop();
    t_invert();
    t_framestep();
    t_fifo();
    t_coding();
    t_shape();
    conclude();
  end
endmodule : tbec_top_tb
